// [shared/sol_pkg.sv]
`default_nettype none
package sol_pkg;

  // Bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Register addresses
  localparam logic [15:0] OSC_OPT_ADDR = 16'h001D;
  localparam logic [15:0] SYS_OPT_ADDR = 16'h001F;
  localparam logic [15:0] CLK_SEL_ADDR = 16'hFFCF;

  // Reset and erased values
  localparam logic [7:0] OPT_RESET_VAL = 8'h00;
  localparam logic [7:0] FLASH_ERASED_VAL = 8'hFF;
  localparam logic [7:0] READ_IDLE_VAL = 8'h00;

  // Implemented bits; unimplemented ones read as zero
  localparam logic [7:0] SYS_OPT_MASK = 8'hFF;
  localparam logic [7:0] OSC_OPT_MASK = 8'hF9;

  // System option latch fields
  localparam int WDOG_RATE_BIT = 7;
  localparam int MON_IN_STOP_BIT = 6;
  localparam int MON_RST_DIS_BIT = 5;
  localparam int MAIN_SUP_DIS_BIT = 4;
  localparam int REG_SUP_DIS_BIT = 3;
  localparam int SHORT_REC_BIT = 2;
  localparam int STOP_EN_BIT = 1;
  localparam int WDOG_DIS_BIT = 0;

  // Oscillator option latch fields
  localparam int INTERNAL_OSC_CLOCK_SLEEP_OFF_BIT = 7;
  localparam int RC_SLEEP_ON_BIT = 6;
  localparam int XTAL_SLEEP_ON_BIT = 5;
  localparam int TB_SRC_HI_BIT = 4;
  localparam int TB_SRC_LO_BIT = 3;
  localparam int SERIAL_CLK_SEL_BIT = 0;

  // Clock-select flash byte fields
  localparam int MAIN_OSC_HI_BIT = 7;
  localparam int MAIN_OSC_LO_BIT = 6;

  // Two-bit source codes
  localparam logic [1:0] TB_SRC_INTERNAL_OSC_CLOCK = 2'h0;
  localparam logic [1:0] TB_SRC_RC = 2'h1;
  localparam logic [1:0] TB_SRC_XTAL = 2'h2;
  localparam logic [1:0] MAIN_OSC_INTERNAL_OSC_CLOCK = 2'h1;
  localparam logic [1:0] MAIN_OSC_RC = 2'h2;
  localparam logic [1:0] MAIN_OSC_XTAL = 2'h3;

  // One-hot oscillator selections: bit0 internal, bit1 RC, bit2 crystal
  localparam logic [2:0] SEL_INTERNAL_OSC_CLOCK = 3'h1;
  localparam logic [2:0] SEL_RC = 3'h2;
  localparam logic [2:0] SEL_XTAL = 3'h4;
  localparam logic [2:0] SEL_NONE = 3'h0;

  // Timing counts, in internal oscillator cycles
  localparam int WDOG_CNT_W = 18;
  localparam logic [17:0] WDOG_SHORT_CYC = 18'h01FF0;
  localparam logic [17:0] WDOG_LONG_CYC = 18'h3FFF0;
  localparam int REC_CNT_W = 13;
  localparam logic [12:0] REC_SHORT_CYC = 13'h0020;
  localparam logic [12:0] REC_LONG_CYC = 13'h1000;

endpackage
`default_nettype wire

// [sim/sol_top_props.sv]
`timescale 1ns/1ps
`default_nettype none
module sol_top_props (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  // Register port
  input wire logic [15:0] I_ADDR,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  // Other inputs
  input wire logic [7:0] I_FLASH_BYTE,
  input wire logic I_STOP_OPCODE,
  input wire logic I_MON_RESET_REQ,
  // Watched outputs
  input wire logic O_MON_RESET,
  input wire logic O_STOP_EXEC,
  input wire logic O_STOP_ILLEGAL,
  input wire logic O_RECOVERY_BUSY,
  input wire logic O_RESUME,
  input wire logic [2:0] O_TB_SEL,
  input wire logic [2:0] O_MAIN_OSC_SEL,
  input wire logic O_SYS_LOCKED
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);
  wire logic mapped = (I_ADDR == sol_pkg::OSC_OPT_ADDR) || (I_ADDR == sol_pkg::SYS_OPT_ADDR) ||
    (I_ADDR == sol_pkg::CLK_SEL_ADDR);
  ////////////////////////////////////////////////////////////////////////////////
  a_read_idle: assert property (!I_RD |=> O_RDATA == 8'h00) else $error("read data not idle");
  a_unmapped_zero: assert property (I_RD && !mapped |=> O_RDATA == 8'h00) else $error("unmapped read");
  a_osc_gap_bits: assert property (I_RD && I_ADDR == sol_pkg::OSC_OPT_ADDR |=> O_RDATA[2:1] == 2'h0)
    else $error("osc latch gap bits set");
  a_flash_read: assert property (I_RD && I_ADDR == sol_pkg::CLK_SEL_ADDR |=>
    O_RDATA == $past(I_FLASH_BYTE)) else $error("flash byte read wrong");
  a_lock_sticky: assert property (O_SYS_LOCKED |=> O_SYS_LOCKED) else $error("lock dropped");
  a_lock_sets: assert property (I_WR && I_ADDR == sol_pkg::SYS_OPT_ADDR |=> ##1 O_SYS_LOCKED)
    else $error("lock not set");
  a_mon_reset_cause: assert property (O_MON_RESET |-> $past(I_MON_RESET_REQ))
    else $error("monitor reset without request");
  a_stop_one_way: assert property (O_STOP_EXEC || O_STOP_ILLEGAL |-> !(O_STOP_EXEC && O_STOP_ILLEGAL) &&
    $past(I_STOP_OPCODE)) else $error("stop opcode outcome wrong");
  a_resume_pulse: assert property (O_RESUME |-> !O_RECOVERY_BUSY ##1 !O_RESUME)
    else $error("resume not a single pulse");
  a_main_osc_xtal: assert property (I_FLASH_BYTE[7:6] == 2'h3 |=> O_MAIN_OSC_SEL == 3'h4)
    else $error("main osc select wrong");
  a_tb_onehot: assert property ($onehot0(O_TB_SEL)) else $error("timebase select not one-hot");
endmodule // sol_top_props
bind sol_top sol_top_props u_props (.I_CLOCK, .I_SYS_RST, .I_ADDR, .I_WR, .I_RD, .O_RDATA, .I_FLASH_BYTE,
  .I_STOP_OPCODE, .I_MON_RESET_REQ, .O_MON_RESET, .O_STOP_EXEC, .O_STOP_ILLEGAL, .O_RECOVERY_BUSY,
  .O_RESUME, .O_TB_SEL, .O_MAIN_OSC_SEL, .O_SYS_LOCKED);
`default_nettype wire

// [sim/sol_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
module sol_top_test;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, in_stop = 1'b0, stop_exit = 1'b0, by_pin = 1'b0;
  logic tick = 1'b1, stop_op = 1'b0, mon_req = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, flash = 8'hFF, rdata;
  logic wdog_en, main_en, reg_en, mon_stop, mon_rst, stop_exec, stop_ill, busy, resume;
  logic internal_osc_clock_run, rc_run, xtal_run, ser_bus, sys_lk, osc_lk;
  logic [17:0] wdog_to;
  logic [2:0] tb_sel, osc_sel;
  int miscompares = 0;
  int samples_checked = 0;
  always #25 clk = ~clk;
  sol_top DUT (.I_CLOCK(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_FLASH_BYTE(flash), .I_IN_STOP(in_stop), .I_STOP_EXIT(stop_exit),
    .I_EXIT_BY_PIN(by_pin), .I_INTERNAL_OSC_CLOCK_TICK(tick), .I_STOP_OPCODE(stop_op), .I_MON_RESET_REQ(mon_req),
    .O_WDOG_EN(wdog_en), .O_WDOG_TIMEOUT(wdog_to), .O_MAIN_MON_EN(main_en), .O_REG_MON_EN(reg_en),
    .O_MON_STOP_EN(mon_stop), .O_MON_RESET(mon_rst), .O_STOP_EXEC(stop_exec), .O_STOP_ILLEGAL(stop_ill),
    .O_RECOVERY_BUSY(busy), .O_RESUME(resume), .O_INTERNAL_OSC_CLOCK_RUN(internal_osc_clock_run), .O_RC_RUN(rc_run),
    .O_XTAL_RUN(xtal_run), .O_TB_SEL(tb_sel), .O_SERIAL_CLK_BUS(ser_bus), .O_MAIN_OSC_SEL(osc_sel),
    .O_SYS_LOCKED(sys_lk), .O_OSC_LOCKED(osc_lk));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("Checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Data stands one cycle only, so it is looked at right after the answer edge
  task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({10'h000, rdata}, {10'h000, e});
  endtask
  // Two edges cover the write-to-output and input-to-output latencies
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic recovery(input logic pin, input int exp);
    int n;
    @(posedge clk);
    stop_exit <= 1'b1;
    by_pin <= pin;
    @(posedge clk);
    stop_exit <= 1'b0;
    #1;
    chk({17'h00000, busy}, 18'h00001);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (resume !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      miscompares++;
      give_verdict();
    end
    chk(18'(n), 18'(exp));
    chk({16'h0000, busy, resume}, 18'h00001);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_state;
    settle();
    rd_reg(16'h001D, 8'h00);
    rd_reg(16'h001F, 8'h00);
    chk({16'h0000, sys_lk, osc_lk}, 18'h00000);
    chk({15'h0000, wdog_en, ser_bus, internal_osc_clock_run}, 18'h00005);
    chk(wdog_to, 18'h3FFF0);
    chk({15'h0000, tb_sel}, 18'h00001);
  endtask
  task automatic t_write_once;
    wr_reg(16'h001F, 8'hA5);
    rd_reg(16'h001F, 8'hA5);
    chk({17'h00000, osc_lk}, 18'h00000);
    wr_reg(16'h001F, 8'h5A);
    rd_reg(16'h001F, 8'hA5);
    wr_reg(16'h001D, 8'hFF);
    rd_reg(16'h001D, 8'hF9);
    wr_reg(16'h001D, 8'h00);
    rd_reg(16'h001D, 8'hF9);
    rd_reg(16'h001E, 8'h00);
  endtask
  // Rate, short recovery and reset-disable set; stop opcode disabled
  task automatic t_config_a;
    flash <= 8'h7F;
    mon_req <= 1'b1;
    stop_op <= 1'b1;
    settle();
    chk(wdog_to, 18'h01FF0);
    chk({14'h0000, wdog_en, mon_rst, stop_exec, stop_ill}, 18'h00001);
    chk({15'h0000, main_en, reg_en, mon_stop}, 18'h00006);
    chk({14'h0000, tb_sel, ser_bus}, 18'h00001);
    mon_req <= 1'b0;
    stop_op <= 1'b0;
    in_stop <= 1'b1;
    settle();
    chk({13'h0000, main_en, reg_en, internal_osc_clock_run, rc_run, xtal_run}, 18'h00003);
    in_stop <= 1'b0;
    recovery(1'b0, 32);
    recovery(1'b1, 4096);
  endtask
  // Second setup after a fresh reset: opposite sense of most bits
  task automatic t_config_b;
    do_reset();
    wr_reg(16'h001F, 8'h52);
    wr_reg(16'h001D, 8'h00);
    mon_req <= 1'b1;
    stop_op <= 1'b1;
    in_stop <= 1'b1;
    settle();
    chk(wdog_to, 18'h3FFF0);
    chk({14'h0000, wdog_en, mon_rst, stop_exec, stop_ill}, 18'h0000E);
    chk({15'h0000, main_en, reg_en, mon_stop}, 18'h00003);
    chk({15'h0000, internal_osc_clock_run, rc_run, xtal_run}, 18'h00004);
    mon_req <= 1'b0;
    stop_op <= 1'b0;
    in_stop <= 1'b0;
    recovery(1'b0, 4096);
  endtask
  task automatic t_tb_codes;
    for (int c = 0; c < 4; c++) begin
      do_reset();
      wr_reg(16'h001D, {3'b000, 2'(c), 3'b000});
      settle();
      chk({15'h0000, tb_sel}, (c == 3) ? 18'h00000 : 18'(1 << c));
      chk({17'h00000, ser_bus}, 18'h00000);
    end
  endtask
  task automatic t_flash;
    for (int c = 0; c < 4; c++) begin
      flash <= {2'(c), 6'h3F};
      settle();
      chk({15'h0000, osc_sel}, (c == 0) ? 18'h00000 : 18'(1 << (c - 1)));
      wr_reg(16'hFFCF, 8'h00);
      rd_reg(16'hFFCF, {2'(c), 6'h3F});
    end
    @(posedge clk);
    rst <= 1'b1;
    settle();
    chk({15'h0000, osc_sel}, 18'h00004);
    @(posedge clk);
    rst <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset_state();
    t_write_once();
    t_config_a();
    t_config_b();
    t_tb_codes();
    t_flash();
    give_verdict();
  end
endmodule // sol_top_test
`default_nettype wire

// [verilog/sol_once_latch.sv]
`timescale 1ns/1ps
`default_nettype none
module sol_once_latch #(
  parameter logic [7:0] IMPL_MASK = 8'hFF
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Write port
  input wire logic i_we,
  input wire logic [7:0] i_wdata,
  // State
  output logic [7:0] o_value,
  output logic o_locked
);

  logic [7:0] value_reg;
  logic locked_reg;
  wire logic take_write = i_we & ~locked_reg;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      value_reg <= sol_pkg::OPT_RESET_VAL;
      locked_reg <= 1'b0;
    end else if (take_write) begin
      value_reg <= i_wdata & IMPL_MASK;
      locked_reg <= 1'b1;
    end
  end

  assign o_value = value_reg;
  assign o_locked = locked_reg;

endmodule // sol_once_latch
`default_nettype wire

// [verilog/sol_recovery_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module sol_recovery_timer (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Control
  input wire logic i_start,
  input wire logic i_via_pin,
  input wire logic i_short,
  input wire logic i_tick,
  // Status
  output logic o_busy,
  output logic o_done
);

  typedef enum logic {TMR_IDLE, TMR_COUNT} sol_tmr_state_t;

  sol_tmr_state_t state_reg;
  logic [12:0] cnt_reg;
  logic [12:0] target_reg;
  logic done_reg;

  // Pin wake always takes the long delay
  wire logic use_short = i_short & ~i_via_pin;
  wire logic [12:0] load_target = use_short ? sol_pkg::REC_SHORT_CYC : sol_pkg::REC_LONG_CYC;
  wire logic last_tick = i_tick & (cnt_reg == target_reg - 13'h0001);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_reg <= TMR_IDLE;
      cnt_reg <= 13'h0000;
      target_reg <= sol_pkg::REC_LONG_CYC;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (state_reg)
        TMR_IDLE: begin
          if (i_start) begin
            state_reg <= TMR_COUNT;
            cnt_reg <= 13'h0000;
            target_reg <= load_target;
          end
        end
        TMR_COUNT: begin
          if (i_start) begin
            cnt_reg <= 13'h0000;
            target_reg <= load_target;
          end else if (last_tick) begin
            state_reg <= TMR_IDLE;
            done_reg <= 1'b1;
          end else if (i_tick) begin
            cnt_reg <= cnt_reg + 13'h0001;
          end
        end
      endcase
    end
  end

  assign o_busy = (state_reg == TMR_COUNT);
  assign o_done = done_reg;

endmodule // sol_recovery_timer
`default_nettype wire

// [verilog/sol_top.sv]
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Each option latch takes one write after reset; later writes are ignored.
// - Reset clears every bit of both option latches.
// - Both option latches read back their contents at any time.
// - Oscillator latch at 0x001D, system latch at 0x001F in data space.
// - Watchdog rate bit: set gives 8176 cycles, clear gives 262128 cycles.
// - Monitor runs in stop only if stop bit set and a supply monitor enabled.
// - Monitor reset disable bit set blocks monitor resets; clear passes them.
// - Two disable bits switch off main and regulated supply monitors.
// - Short recovery bit: 32 cycles when set, 4096 cycles when clear.
// - Wake from stop through the reset pin always uses the long delay.
// - Stop enable set runs stop opcode; clear makes it an illegal opcode.
// - Watchdog disable bit set holds the watchdog off; clear enables it.
// - Internal oscillator stops in stop mode when its sleep-off bit is set.
// - RC oscillator keeps running in stop when its bit is set.
// - Crystal oscillator keeps running in stop when its bit is set.
// - Timebase source field: 00 internal, 01 RC, 10 crystal, 11 unused.
// - Serial port clock bit: bus clock when set, oscillator clock when clear.
// - Clock-select byte lives in flash, read-only here, erased reads all ones.
// - Main oscillator select: 01 internal, 10 RC, 11 crystal, 00 unused.
// - Reset leaves the main oscillator select bits untouched.
module sol_top (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  // Register port
  input wire logic [15:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // Nonvolatile clock-select byte from the flash array
  input wire logic [7:0] I_FLASH_BYTE,
  // Processor and power state
  input wire logic I_IN_STOP,
  input wire logic I_STOP_EXIT,
  input wire logic I_EXIT_BY_PIN,
  input wire logic I_INTERNAL_OSC_CLOCK_TICK,
  input wire logic I_STOP_OPCODE,
  input wire logic I_MON_RESET_REQ,
  // Watchdog setup
  output logic O_WDOG_EN,
  output logic [17:0] O_WDOG_TIMEOUT,
  // Low-voltage monitor setup
  output logic O_MAIN_MON_EN,
  output logic O_REG_MON_EN,
  output logic O_MON_STOP_EN,
  output logic O_MON_RESET,
  // Stop handling
  output logic O_STOP_EXEC,
  output logic O_STOP_ILLEGAL,
  output logic O_RECOVERY_BUSY,
  output logic O_RESUME,
  // Oscillator run enables
  output logic O_INTERNAL_OSC_CLOCK_RUN,
  output logic O_RC_RUN,
  output logic O_XTAL_RUN,
  // Clock routing
  output logic [2:0] O_TB_SEL,
  output logic O_SERIAL_CLK_BUS,
  output logic [2:0] O_MAIN_OSC_SEL,
  // Lock status
  output logic O_SYS_LOCKED,
  output logic O_OSC_LOCKED
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] target);
    addr_hit = (addr == target);
  endfunction

  wire logic hit_sys = addr_hit(I_ADDR, sol_pkg::SYS_OPT_ADDR);
  wire logic hit_osc = addr_hit(I_ADDR, sol_pkg::OSC_OPT_ADDR);
  wire logic hit_clk = addr_hit(I_ADDR, sol_pkg::CLK_SEL_ADDR);
  wire logic wr_sys = I_WR & hit_sys;
  wire logic wr_osc = I_WR & hit_osc;

  ////////////////////////////////////////////////////////////////////////////
  // Option latches

  logic [7:0] sys_opt;
  logic [7:0] osc_opt;
  logic sys_locked;
  logic osc_locked;

  sol_once_latch #(
    .IMPL_MASK(sol_pkg::SYS_OPT_MASK)
  ) u_sys_latch (
    .i_clock(I_CLOCK),
    .i_sys_rst(I_SYS_RST),
    .i_we(wr_sys),
    .i_wdata(I_WDATA),
    .o_value(sys_opt),
    .o_locked(sys_locked)
  );

  sol_once_latch #(
    .IMPL_MASK(sol_pkg::OSC_OPT_MASK)
  ) u_osc_latch (
    .i_clock(I_CLOCK),
    .i_sys_rst(I_SYS_RST),
    .i_we(wr_osc),
    .i_wdata(I_WDATA),
    .o_value(osc_opt),
    .o_locked(osc_locked)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction

  wire logic wdog_rate = sys_opt[sol_pkg::WDOG_RATE_BIT];
  wire logic mon_in_stop = sys_opt[sol_pkg::MON_IN_STOP_BIT];
  wire logic mon_rst_dis = sys_opt[sol_pkg::MON_RST_DIS_BIT];
  wire logic main_sup_dis = sys_opt[sol_pkg::MAIN_SUP_DIS_BIT];
  wire logic reg_sup_dis = sys_opt[sol_pkg::REG_SUP_DIS_BIT];
  wire logic short_rec = sys_opt[sol_pkg::SHORT_REC_BIT];
  wire logic stop_en = sys_opt[sol_pkg::STOP_EN_BIT];
  wire logic wdog_dis = sys_opt[sol_pkg::WDOG_DIS_BIT];
  wire logic internal_osc_clock_sleep_off = osc_opt[sol_pkg::INTERNAL_OSC_CLOCK_SLEEP_OFF_BIT];
  wire logic rc_sleep_on = osc_opt[sol_pkg::RC_SLEEP_ON_BIT];
  wire logic xtal_sleep_on = osc_opt[sol_pkg::XTAL_SLEEP_ON_BIT];
  wire logic [1:0] tb_src = {osc_opt[sol_pkg::TB_SRC_HI_BIT], osc_opt[sol_pkg::TB_SRC_LO_BIT]};
  wire logic serial_clk_sel = osc_opt[sol_pkg::SERIAL_CLK_SEL_BIT];
  wire logic [1:0] main_osc = {I_FLASH_BYTE[sol_pkg::MAIN_OSC_HI_BIT], I_FLASH_BYTE[sol_pkg::MAIN_OSC_LO_BIT]};

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Flash byte is only read; programming happens in the flash controller
  wire logic [7:0] rd_mux =
    hit_sys ? sys_opt :
    hit_osc ? osc_opt :
    hit_clk ? I_FLASH_BYTE :
    sol_pkg::READ_IDLE_VAL;
  wire logic [7:0] rdata_next = I_RD ? rd_mux : sol_pkg::READ_IDLE_VAL;

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog and stop decode

  wire logic [17:0] wdog_timeout_next = wdog_rate ? sol_pkg::WDOG_SHORT_CYC : sol_pkg::WDOG_LONG_CYC;
  wire logic wdog_en_next = ~wdog_dis;
  wire logic stop_exec_next = I_STOP_OPCODE & stop_en;
  wire logic stop_illegal_next = I_STOP_OPCODE & ~stop_en;

  ////////////////////////////////////////////////////////////////////////////
  // Low-voltage monitor decode

  // Stop-mode operation needs at least one supply circuit still enabled
  wire logic any_sup_on = ~main_sup_dis | ~reg_sup_dis;
  wire logic mon_stop_en_next = mon_in_stop & any_sup_on;
  wire logic mon_allowed = ~I_IN_STOP | mon_stop_en_next;
  wire logic main_mon_en_next = ~main_sup_dis & mon_allowed;
  wire logic reg_mon_en_next = ~reg_sup_dis & mon_allowed;
  // Software guards stop entry itself when the monitor would be off
  wire logic mon_reset_next = I_MON_RESET_REQ & ~mon_rst_dis;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillators in stop

  wire logic internal_osc_clock_run_next = ~(I_IN_STOP & internal_osc_clock_sleep_off);
  wire logic rc_run_next = ~I_IN_STOP | rc_sleep_on;
  wire logic xtal_run_next = ~I_IN_STOP | xtal_sleep_on;

  ////////////////////////////////////////////////////////////////////////////
  // Clock routing

  logic [2:0] tb_sel_next;
  logic [2:0] main_osc_next;

  always_comb begin
    unique case (tb_src)
      sol_pkg::TB_SRC_INTERNAL_OSC_CLOCK: tb_sel_next = sol_pkg::SEL_INTERNAL_OSC_CLOCK;
      sol_pkg::TB_SRC_RC: tb_sel_next = sol_pkg::SEL_RC;
      sol_pkg::TB_SRC_XTAL: tb_sel_next = sol_pkg::SEL_XTAL;
      default: tb_sel_next = sol_pkg::SEL_NONE;
    endcase
  end

  always_comb begin
    unique case (main_osc)
      sol_pkg::MAIN_OSC_INTERNAL_OSC_CLOCK: main_osc_next = sol_pkg::SEL_INTERNAL_OSC_CLOCK;
      sol_pkg::MAIN_OSC_RC: main_osc_next = sol_pkg::SEL_RC;
      sol_pkg::MAIN_OSC_XTAL: main_osc_next = sol_pkg::SEL_XTAL;
      default: main_osc_next = sol_pkg::SEL_NONE;
    endcase
  end

  wire logic serial_clk_bus_next = serial_clk_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Stop recovery
  // Short delay with a crystal is left to software; not enforced here

  sol_recovery_timer u_recovery (
    .i_clock(I_CLOCK),
    .i_sys_rst(I_SYS_RST),
    .i_start(I_STOP_EXIT),
    .i_via_pin(I_EXIT_BY_PIN),
    .i_short(short_rec),
    .i_tick(I_INTERNAL_OSC_CLOCK_TICK),
    .o_busy(O_RECOVERY_BUSY),
    .o_done(O_RESUME)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output registers

  logic [7:0] rdata_reg;
  logic wdog_en_reg;
  logic [17:0] wdog_timeout_reg;
  logic main_mon_en_reg;
  logic reg_mon_en_reg;
  logic mon_stop_en_reg;
  logic mon_reset_reg;
  logic stop_exec_reg;
  logic stop_illegal_reg;
  logic internal_osc_clock_run_reg;
  logic rc_run_reg;
  logic xtal_run_reg;
  logic [2:0] tb_sel_reg;
  logic serial_clk_bus_reg;
  logic [2:0] main_osc_reg;
  logic sys_locked_reg;
  logic osc_locked_reg;

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      rdata_reg <= sol_pkg::READ_IDLE_VAL;
      mon_reset_reg <= 1'b0;
      stop_exec_reg <= 1'b0;
      stop_illegal_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      mon_reset_reg <= mon_reset_next;
      stop_exec_reg <= stop_exec_next;
      stop_illegal_reg <= stop_illegal_next;
    end
  end

  // Mirrors of the option latches follow the cleared latches through reset
  always_ff @(posedge I_CLOCK) begin
    wdog_en_reg <= wdog_en_next;
    wdog_timeout_reg <= wdog_timeout_next;
    main_mon_en_reg <= main_mon_en_next;
    reg_mon_en_reg <= reg_mon_en_next;
    mon_stop_en_reg <= mon_stop_en_next;
    internal_osc_clock_run_reg <= internal_osc_clock_run_next;
    rc_run_reg <= rc_run_next;
    xtal_run_reg <= xtal_run_next;
    tb_sel_reg <= tb_sel_next;
    serial_clk_bus_reg <= serial_clk_bus_next;
    sys_locked_reg <= sys_locked;
    osc_locked_reg <= osc_locked;
  end

  // No reset term: the selection stems from nonvolatile storage
  always_ff @(posedge I_CLOCK) begin
    main_osc_reg <= main_osc_next;
  end

  assign O_RDATA = rdata_reg;
  assign O_WDOG_EN = wdog_en_reg;
  assign O_WDOG_TIMEOUT = wdog_timeout_reg;
  assign O_MAIN_MON_EN = main_mon_en_reg;
  assign O_REG_MON_EN = reg_mon_en_reg;
  assign O_MON_STOP_EN = mon_stop_en_reg;
  assign O_MON_RESET = mon_reset_reg;
  assign O_STOP_EXEC = stop_exec_reg;
  assign O_STOP_ILLEGAL = stop_illegal_reg;
  assign O_INTERNAL_OSC_CLOCK_RUN = internal_osc_clock_run_reg;
  assign O_RC_RUN = rc_run_reg;
  assign O_XTAL_RUN = xtal_run_reg;
  assign O_TB_SEL = tb_sel_reg;
  assign O_SERIAL_CLK_BUS = serial_clk_bus_reg;
  assign O_MAIN_OSC_SEL = main_osc_reg;
  assign O_SYS_LOCKED = sys_locked_reg;
  assign O_OSC_LOCKED = osc_locked_reg;

endmodule // sol_top
`default_nettype wire
